// >>> core/ps2hp_host.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: Peripheral frame: start, 8 LSB-first, odd parity, stop
// R2: Both lines idle high outside transfers
// R3: Receiver takes one bit per falling clock edge
// R4: Peripheral clock period 30 to 50 us
// R5: Keyboard sends only when both lines high
// R6: Host holds clock low to inhibit peripheral
// R7: Host drives lines by open-drain pull-down only
// R8: Held key code repeats about every 100 ms
// R9: F0 prefix marks a key release
// R10: E0 prefix marks extended keys, tracked
// R11: Host keeps shift state for characters
// R12: ED, acknowledge FA, then LED byte
// R13: Keyboard echoes EE with EE
// R14: F3, acknowledge, then repeat-rate byte
// R15: FE makes keyboard resend last code
// R16: FF resets the keyboard
// R17: Mouse report is three frames, status first
// R18: Sign bits set for left and down motion
// R19: Overflow bits flag overflowed movement counts
// R20: Button bits high while button held
// R21: Moving mouse repeats report about 50 ms
// R22: Clock synchronised and filtered before edge detect; only the sender does this, the receiver clocks on the raw ps2_clk_i
// R23: Bad start, parity or stop flags error
// R24: Send: clock low 100 us, data low, release
module ps2hp_host #(
  parameter int unsigned INHIB_CYC = ps2hp_pkg::INHIB_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ps2_clk_i,
  output logic ps2_clk_o,
  output logic ps2_clk_oe_o,
  input wire logic ps2_dat_i,
  output logic ps2_dat_o,
  output logic ps2_dat_oe_o,
  input wire logic mouse_mode_i,
  input wire logic inhibit_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_has_arg_i,
  input wire logic [7:0] cmd_arg_i,
  output logic cmd_busy_o,
  output logic cmd_ack_o,
  output logic tx_nack_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic frame_err_o,
  output logic key_valid_o,
  output logic [7:0] key_code_o,
  output logic key_ext_o,
  output logic key_break_o,
  output logic key_shift_o,
  output logic mouse_valid_o,
  output logic [8:0] mouse_dx_o,
  output logic [8:0] mouse_dy_o,
  output logic mouse_btn_l_o,
  output logic mouse_btn_r_o,
  output logic horiz_overflow_bit_o,
  output logic vert_overflow_bit_o
);

  typedef enum logic [2:0] {TX_IDLE, TX_INHIB, TX_REQ, TX_BITS, TX_ACK, TX_END,
    TX_WAIT_FA} ps2hp_tx_e;

  ps2hp_link_if lnk ();

  ps2hp_rx_link u_rx (
    .ps2_clk_i (ps2_clk_i),
    .ps2_dat_i (ps2_dat_i),
    .lnk (lnk.link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and clock filter
  logic clk_s1_r;
  logic clk_s2_r;
  logic dat_s1_r;
  logic dat_s2_r;
  logic clk_flt_r;
  logic [2:0] flt_cnt_r;
  logic flt_fall_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      dat_s1_r <= 1'b1;
      dat_s2_r <= 1'b1;
    end
    else
    begin
      clk_s1_r <= ps2_clk_i;
      clk_s2_r <= clk_s1_r;
      dat_s1_r <= ps2_dat_i;
      dat_s2_r <= dat_s1_r;
    end
  end

  // Short glitches restart the count, so they never make an edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_flt_r <= 1'b1;
      flt_cnt_r <= 3'h0;
      flt_fall_r <= 1'b0;
    end
    else
    begin
      flt_fall_r <= 1'b0;
      if (clk_s2_r == clk_flt_r)
        flt_cnt_r <= 3'h0;
      else if (flt_cnt_r == ps2hp_pkg::FILT_LAST)
      begin
        clk_flt_r <= clk_s2_r; // [R22]
        flt_cnt_r <= 3'h0;
        flt_fall_r <= !clk_s2_r; // [R22]
      end
      else
        flt_cnt_r <= flt_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame arrival from the link domain
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic rx_new;
  logic rx_ok;

  // Hold clears the link toggle at once, so these copies clear with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || lnk.hold)
    begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end
    else
    begin
      tgl_s1_r <= lnk.done_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // The byte sits still for ten link edges after the toggle, ample time
  assign rx_new = tgl_s2_r ^ tgl_s3_r;
  assign rx_ok = rx_new && !lnk.par_err && !lnk.frm_err; // [R23]

  ////////////////////////////////////////////////////////////////////////////
  // Command sender
  ps2hp_tx_e tx_st_r;
  logic [15:0] tx_cnt_r;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_bit_r;
  logic cur_bit_r;
  logic arg_pend_r;
  logic [7:0] arg_r;
  logic tx_busy;

  assign tx_busy = (tx_st_r != TX_IDLE) && (tx_st_r != TX_WAIT_FA);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= 16'h0;
      tx_sh_r <= 10'h3ff;
      tx_bit_r <= 4'h0;
      cur_bit_r <= 1'b1;
      arg_pend_r <= 1'b0;
      arg_r <= 8'h0;
      tx_nack_o <= 1'b0;
    end
    else
    begin
      tx_nack_o <= 1'b0;
      case (tx_st_r)
        TX_IDLE:
          if (cmd_valid_i && !inhibit_i)
          begin
            tx_sh_r <= {1'b1, ps2hp_pkg::ps2hp_odd_par(cmd_byte_i), cmd_byte_i};
            arg_pend_r <= cmd_has_arg_i;
            arg_r <= cmd_arg_i;
            tx_cnt_r <= 16'h0;
            tx_st_r <= TX_INHIB;
          end
        TX_INHIB:
          if (tx_cnt_r == 16'(INHIB_CYC - 1)) // [R24]
          begin
            cur_bit_r <= 1'b0;
            tx_st_r <= TX_REQ;
          end
          else
            tx_cnt_r <= tx_cnt_r + 16'h1;
        TX_REQ:
        begin
          tx_bit_r <= 4'h0;
          tx_st_r <= TX_BITS;
        end
        TX_BITS:
          if (flt_fall_r)
          begin
            cur_bit_r <= tx_sh_r[0]; // [R24]
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == ps2hp_pkg::TX_LAST)
              tx_st_r <= TX_ACK;
          end
        TX_ACK:
          if (flt_fall_r)
          begin
            tx_nack_o <= dat_s2_r;
            tx_st_r <= TX_END;
          end
        TX_END:
          if (clk_flt_r && dat_s2_r)
            tx_st_r <= arg_pend_r ? TX_WAIT_FA : TX_IDLE;
        TX_WAIT_FA:
          if (rx_new)
          begin
            if (rx_ok && lnk.rx_byte == ps2hp_pkg::CODE_ACK) // [R12] [R14]
            begin
              tx_sh_r <= {1'b1, ps2hp_pkg::ps2hp_odd_par(arg_r), arg_r};
              arg_pend_r <= 1'b0;
              tx_cnt_r <= 16'h0;
              tx_st_r <= TX_INHIB;
            end
            else
              tx_st_r <= TX_IDLE;
          end
        default:
          tx_st_r <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain pins: only ever pull low, release otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ps2_clk_o <= 1'b0;
      ps2_dat_o <= 1'b0;
      ps2_clk_oe_o <= 1'b0;
      ps2_dat_oe_o <= 1'b0;
      cmd_busy_o <= 1'b0;
    end
    else
    begin
      ps2_clk_o <= 1'b0; // [R7]
      ps2_dat_o <= 1'b0; // [R7]
      ps2_clk_oe_o <= (tx_st_r == TX_INHIB) || (tx_st_r == TX_REQ) ||
        (!tx_busy && inhibit_i); // [R6] [R2]
      ps2_dat_oe_o <= (tx_st_r == TX_REQ) || (tx_st_r == TX_BITS && !cur_bit_r); // [R2]
      cmd_busy_o <= (tx_st_r != TX_IDLE);
    end
  end

  // Receiver is held while the host owns the bus or is in reset
  always_ff @(posedge clk_i)
  begin
    lnk.hold <= rst_i || inhibit_i || tx_busy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte decode: keyboard prefixes and shift, or mouse report assembly
  logic ext_r;
  logic brk_r;
  logic shift_r;
  logic [1:0] m_cnt_r;
  logic [7:0] m_stat_r;
  logic [7:0] m_x_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_valid_o <= 1'b0;
      rx_byte_o <= 8'h0;
      frame_err_o <= 1'b0;
      cmd_ack_o <= 1'b0;
      key_valid_o <= 1'b0;
      key_code_o <= 8'h0;
      key_ext_o <= 1'b0;
      key_break_o <= 1'b0;
      key_shift_o <= 1'b0;
      ext_r <= 1'b0;
      brk_r <= 1'b0;
      shift_r <= 1'b0;
      m_cnt_r <= 2'h0;
      m_stat_r <= 8'h0;
      m_x_r <= 8'h0;
      mouse_valid_o <= 1'b0;
      mouse_dx_o <= 9'h0;
      mouse_dy_o <= 9'h0;
      mouse_btn_l_o <= 1'b0;
      mouse_btn_r_o <= 1'b0;
      horiz_overflow_bit_o <= 1'b0;
      vert_overflow_bit_o <= 1'b0;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      frame_err_o <= 1'b0;
      cmd_ack_o <= 1'b0;
      key_valid_o <= 1'b0;
      mouse_valid_o <= 1'b0;
      if (rx_new && !rx_ok)
      begin
        frame_err_o <= 1'b1; // [R23]
        m_cnt_r <= 2'h0;
      end
      else if (rx_ok)
      begin
        rx_valid_o <= 1'b1;
        rx_byte_o <= lnk.rx_byte;
        cmd_ack_o <= (lnk.rx_byte == ps2hp_pkg::CODE_ACK);
        if (mouse_mode_i)
        begin
          m_cnt_r <= (m_cnt_r == 2'h2) ? 2'h0 : m_cnt_r + 2'h1;
          if (m_cnt_r == 2'h0)
            m_stat_r <= lnk.rx_byte;
          else if (m_cnt_r == 2'h1)
            m_x_r <= lnk.rx_byte;
          else
          begin
            mouse_valid_o <= 1'b1;
            mouse_dx_o <= {m_stat_r[ps2hp_pkg::ST_HORIZ_SIGN], m_x_r}; // [R18]
            mouse_dy_o <= {m_stat_r[ps2hp_pkg::ST_VERT_SIGN], lnk.rx_byte}; // [R18]
            horiz_overflow_bit_o <= m_stat_r[ps2hp_pkg::ST_HORIZ_OVF]; // [R19]
            vert_overflow_bit_o <= m_stat_r[ps2hp_pkg::ST_VERT_OVF]; // [R19]
            mouse_btn_l_o <= m_stat_r[ps2hp_pkg::ST_BTN_L]; // [R20]
            mouse_btn_r_o <= m_stat_r[ps2hp_pkg::ST_BTN_R]; // [R20]
          end
        end
        else if (lnk.rx_byte == ps2hp_pkg::CODE_EXT)
          ext_r <= 1'b1; // [R10]
        else if (lnk.rx_byte == ps2hp_pkg::CODE_BREAK)
          brk_r <= 1'b1; // [R9]
        else if (lnk.rx_byte != ps2hp_pkg::CODE_ACK && lnk.rx_byte != ps2hp_pkg::CODE_ECHO)
        begin
          key_valid_o <= 1'b1;
          key_code_o <= lnk.rx_byte;
          key_ext_o <= ext_r; // [R10]
          key_break_o <= brk_r; // [R9]
          key_shift_o <= shift_r; // [R11]
          ext_r <= 1'b0;
          brk_r <= 1'b0;
          if (!ext_r && (lnk.rx_byte == ps2hp_pkg::CODE_LSHIFT ||
              lnk.rx_byte == ps2hp_pkg::CODE_RSHIFT))
            shift_r <= !brk_r; // [R11]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [15:0] oe_run_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ps2_clk_oe_o)
      oe_run_r <= 16'h0;
    else if (oe_run_r != 16'hffff)
      oe_run_r <= oe_run_r + 16'h1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_quiet;
    (tx_st_r == TX_IDLE && !inhibit_i) [*2];
  endsequence

  sequence s_good_byte(logic [7:0] b);
    rx_ok && !mouse_mode_i && lnk.rx_byte == b;
  endsequence

  idle_release_a: assert property (s_quiet |-> !ps2_clk_oe_o && !ps2_dat_oe_o) // [R2]
    else $error("Bus not released while idle");
  pull_down_a: assert property ((ps2_clk_oe_o |-> !ps2_clk_o) and (ps2_dat_oe_o |-> !ps2_dat_o)) // [R7]
    else $error("Pin driven high");
  inhibit_hold_a: assert property (inhibit_i && !tx_busy |=> ps2_clk_oe_o) // [R6]
    else $error("Inhibit did not pull clock low");
  inhib_len_a: assert property ($fell(ps2_clk_oe_o) && tx_st_r == TX_BITS |-> oe_run_r >= 16'(INHIB_CYC)) // [R24]
    else $error("Clock held low too briefly");
  req_order_a: assert property ($fell(ps2_clk_oe_o) && tx_busy |-> ps2_dat_oe_o && $past(ps2_dat_oe_o)) // [R24]
    else $error("Data not low before clock release");
  filt_edge_a: assert property (flt_fall_r |-> $past(clk_s2_r, 1) == 1'b0 && $past(clk_s2_r, 8) == 1'b0) // [R22]
    else $error("Falling edge without settled low");
  frame_err_a: assert property (rx_new && !rx_ok |=> frame_err_o && !rx_valid_o && !key_valid_o) // [R23]
    else $error("Bad frame delivered");
  break_pref_a: assert property (s_good_byte(ps2hp_pkg::CODE_BREAK) |=> brk_r && !key_valid_o) // [R9]
    else $error("Break prefix lost");
  ext_pref_a: assert property (s_good_byte(ps2hp_pkg::CODE_EXT) |=> ext_r && !key_valid_o) // [R10]
    else $error("Extended prefix lost");
  mouse_sign_a: assert property (mouse_valid_o |-> mouse_dx_o[8] == m_stat_r[ps2hp_pkg::ST_HORIZ_SIGN]) // [R18]
    else $error("Horizontal sign mismatch");
  arg_follow_a: assert property (tx_st_r == TX_WAIT_FA && rx_ok && lnk.rx_byte == ps2hp_pkg::CODE_ACK
    |=> tx_st_r == TX_INHIB && tx_sh_r[7:0] == arg_r) // [R12] [R14]
    else $error("Argument byte not sent after acknowledge");

endmodule : ps2hp_host
`default_nettype wire

// >>> core/ps2hp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ps2hp_link_if;
  logic [7:0] rx_byte;
  logic par_err;
  logic frm_err;
  logic done_tgl;
  logic hold;
  modport link (output rx_byte, output par_err, output frm_err, output done_tgl, input hold);
  modport sys (input rx_byte, input par_err, input frm_err, input done_tgl, output hold);
endinterface : ps2hp_link_if
`default_nettype wire

// >>> core/ps2hp_pkg.sv
package ps2hp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned INHIB_TIME_NS = 100000;
  localparam int unsigned INHIB_CYC = (INHIB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock filter: a new level must be seen on eight samples in a row
  localparam logic [2:0] FILT_LAST = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam logic [3:0] FRAME_LAST = 4'ha;
  localparam logic [3:0] TX_LAST = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Byte values
  localparam logic [7:0] CODE_BREAK = 8'hf0;
  localparam logic [7:0] CODE_EXT = 8'he0;
  localparam logic [7:0] CODE_ACK = 8'hfa;
  localparam logic [7:0] CODE_ECHO = 8'hee;
  localparam logic [7:0] CODE_LSHIFT = 8'h12;
  localparam logic [7:0] CODE_RSHIFT = 8'h59;
  localparam logic [7:0] CMD_LEDS = 8'hed;
  localparam logic [7:0] CMD_RATE = 8'hf3;

  ////////////////////////////////////////////////////////////////////////////
  // Mouse status byte fields
  localparam int unsigned ST_BTN_L = 0;
  localparam int unsigned ST_BTN_R = 1;
  localparam int unsigned ST_HORIZ_SIGN = 4;
  localparam int unsigned ST_VERT_SIGN = 5;
  localparam int unsigned ST_HORIZ_OVF = 6;
  localparam int unsigned ST_VERT_OVF = 7;

  function automatic logic ps2hp_odd_par(input logic [7:0] d);
    return ~(^d);
  endfunction : ps2hp_odd_par

endpackage : ps2hp_pkg

// >>> core/ps2hp_rx_link.sv
`timescale 1ns/100ps
`default_nettype none
module ps2hp_rx_link (
  input wire logic ps2_clk_i,
  input wire logic ps2_dat_i,
  ps2hp_link_if.link lnk
);

  logic [3:0] cnt_r;
  logic [9:0] sh_r;

  ////////////////////////////////////////////////////////////////////////////
  // Hold clears the link side at once: it comes from a system flop and only
  // moves while the bus rests; syncing it on link edges would eat the first
  // bits of the next frame, as the link clock only runs inside frames
  always_ff @(negedge ps2_clk_i or posedge lnk.hold)
  begin
    if (lnk.hold)
    begin
      cnt_r <= 4'h0;
      lnk.done_tgl <= 1'b0;
    end
    else if (cnt_r == 4'h0 && ps2_dat_i)
      cnt_r <= 4'h0;
    else if (cnt_r == ps2hp_pkg::FRAME_LAST)
    begin
      cnt_r <= 4'h0;
      lnk.done_tgl <= !lnk.done_tgl;
    end
    else
      cnt_r <= cnt_r + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One bit per falling link edge; a high first bit is no start, so resync
  always_ff @(negedge ps2_clk_i)
  begin
    sh_r <= {ps2_dat_i, sh_r[9:1]}; // [R3]
    if (cnt_r == ps2hp_pkg::FRAME_LAST)
    begin
      lnk.rx_byte <= sh_r[8:1];
      lnk.par_err <= (sh_r[9] != ps2hp_pkg::ps2hp_odd_par(sh_r[8:1])) || sh_r[0]; // [R23]
      lnk.frm_err <= !ps2_dat_i; // [R23]
    end
  end

endmodule : ps2hp_rx_link
`default_nettype wire

// >>> dv/ps2_host_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ps2_host_port_tb;
  localparam int INHIB = 50;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic mouse_mode_i = 1'b0;
  logic inhibit_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_byte_i = 8'h00;
  logic cmd_has_arg_i = 1'b0;
  logic [7:0] cmd_arg_i = 8'h00;
  logic ps2_clk_o, ps2_clk_oe_o, ps2_dat_o, ps2_dat_oe_o, cmd_busy_o, cmd_ack_o, tx_nack_o;
  logic rx_valid_o, frame_err_o, key_valid_o, key_ext_o, key_break_o, key_shift_o;
  logic mouse_valid_o, mouse_btn_l_o, mouse_btn_r_o, horiz_overflow_bit_o, vert_overflow_bit_o;
  logic [7:0] rx_byte_o, key_code_o, c, last;
  logic [8:0] mouse_dx_o, mouse_dy_o;
  logic kc, kd, m_ext, m_brk, m_shift;
  logic [31:0] rnd = 32'h3a50747f;
  logic [7:0] exp_rx[$], ms_b[3];
  logic [10:0] exp_key[$];
  logic [21:0] exp_ms[$];
  int err_count = 0, n_checks = 0, n_err = 0, n_ack = 0, ms_n = 0;
  // Open-drain lines with pull-ups
  wire ps2_clk_i = ~(ps2_clk_oe_o | kc);
  wire ps2_dat_i = ~(ps2_dat_oe_o | kd);
  always #10 clk_i = ~clk_i;
  ps2hp_host #(.INHIB_CYC(INHIB)) i_dut (.clk_i, .rst_i, .ps2_clk_i, .ps2_clk_o, .ps2_clk_oe_o,
    .ps2_dat_i, .ps2_dat_o, .ps2_dat_oe_o, .mouse_mode_i, .inhibit_i, .cmd_valid_i, .cmd_byte_i,
    .cmd_has_arg_i, .cmd_arg_i, .cmd_busy_o, .cmd_ack_o, .tx_nack_o, .rx_valid_o, .rx_byte_o,
    .frame_err_o, .key_valid_o, .key_code_o, .key_ext_o, .key_break_o, .key_shift_o,
    .mouse_valid_o, .mouse_dx_o, .mouse_dy_o, .mouse_btn_l_o, .mouse_btn_r_o,
    .horiz_overflow_bit_o, .vert_overflow_bit_o);
  ps2hp_kbd_model i_kbd (.ps2_clk_i, .ps2_dat_i, .clk_pull_o(kc), .dat_pull_o(kd));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Reference decoder: prefixes, shift state before event, three-byte reports
  task automatic expect_byte(input logic [7:0] b);
    exp_rx.push_back(b);
    if (b != 8'hfa && b != 8'hee) last = b;
    if (mouse_mode_i)
    begin
      ms_b[ms_n] = b;
      ms_n++;
      if (ms_n == 3) exp_ms.push_back({ms_b[0][4], ms_b[1], ms_b[0][5], ms_b[2], ms_b[0][0],
        ms_b[0][1], ms_b[0][6], ms_b[0][7]});
      if (ms_n == 3) ms_n = 0;
    end
    else if (b == 8'hfa) n_ack++;
    else if (b == 8'he0) m_ext = 1'b1;
    else if (b == 8'hf0) m_brk = 1'b1;
    else if (b != 8'hee)
    begin
      exp_key.push_back({b, m_ext, m_brk, m_shift});
      if (!m_ext && (b == 8'h12 || b == 8'h59)) m_shift = !m_brk;
      m_ext = 1'b0;
      m_brk = 1'b0;
    end
  endtask : expect_byte
  task automatic frame(input logic [7:0] b, input logic bad = 1'b0);
    if (bad) n_err++;
    else expect_byte(b);
    i_kbd.send_byte(b, bad);
  endtask : frame
  task automatic settle(input string t);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      if (exp_rx.size() + exp_key.size() + exp_ms.size() + n_err + n_ack == 0
          && cmd_busy_o === 1'b0) break;
      @(negedge clk_i);
    end
    chk(i < 3000, "results missing");
    if (i >= 3000)
      wrap_up();
    else
      $display("test %s done", t);
  endtask : settle
  task automatic rst(input logic m);
    @(negedge clk_i);
    rst_i = 1'b1;
    mouse_mode_i = m;
    {ms_n, m_ext, m_brk, m_shift} = '0;
    i_kbd.flush();
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    chk(ps2_clk_oe_o === 1'b0 && ps2_dat_oe_o === 1'b0 && cmd_busy_o === 1'b0, "reset");
  endtask : rst
  function automatic logic [7:0] code(input logic [31:0] r);
    return (r[6:0] == 7'h12 || r[6:0] == 7'h59) ? 8'h1c : {1'b0, r[6:0]};
  endfunction : code
  task automatic cmd(input logic [7:0] b, input logic arg_en, input logic [7:0] arg);
    int n;
    if (arg_en) expect_byte(8'hfa);
    expect_byte(b == 8'hee ? 8'hee : (b == 8'hfe ? last : 8'hfa));
    @(negedge clk_i);
    {cmd_byte_i, cmd_has_arg_i, cmd_arg_i, cmd_valid_i} = {b, arg_en, arg, 1'b1};
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    for (n = 0; n < 4 && ps2_clk_oe_o !== 1'b1; n++) @(negedge clk_i);
    chk(cmd_busy_o === 1'b1, "busy");
    for (n = 0; n < 2 * INHIB && ps2_clk_oe_o === 1'b1; n++) @(negedge clk_i);
    chk(n == INHIB + 1 && ps2_dat_oe_o === 1'b1, "clock hold");
    settle("command");
    chk(i_kbd.got_q.size() == (arg_en ? 2 : 1) && i_kbd.got_q[0] === b && i_kbd.bad_n == 0
      && (!arg_en || i_kbd.got_q[1] === arg), "sent frame");
    i_kbd.got_q.delete();
  endtask : cmd
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_i)
  begin
    if (!rst_i) chk(ps2_clk_o === 1'b0 && ps2_dat_o === 1'b0 && tx_nack_o !== 1'b1, "pins");
    if (rx_valid_o === 1'b1) chk(exp_rx.size() > 0 && rx_byte_o === exp_rx.pop_front(), "rx");
    if (frame_err_o === 1'b1) chk(n_err-- > 0, "frame error");
    if (cmd_ack_o === 1'b1) chk(n_ack-- > 0, "ack");
    if (key_valid_o === 1'b1) chk(exp_key.size() > 0 && exp_key.pop_front() ===
      {key_code_o, key_ext_o, key_break_o, key_shift_o}, "key");
    if (mouse_valid_o === 1'b1) chk(exp_ms.size() > 0 && exp_ms.pop_front() ===
      {mouse_dx_o, mouse_dy_o, mouse_btn_l_o, mouse_btn_r_o, horiz_overflow_bit_o,
      vert_overflow_bit_o}, "mouse");
  end
  initial
  begin
    rst(1'b0);
    for (int k = 0; k < 6; k++)
    begin
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      c = code(rnd);
      frame(c);
      frame(8'hf0);
      frame(c);
      frame(8'he0);
      frame(c);
      frame(8'he0);
      frame(8'hf0);
      frame(c);
      frame(8'h12);
      frame(c);
      frame(8'hf0);
      frame(8'h12);
      frame(c, k[0]);
    end
    settle("keys");
    cmd(8'hed, 1'b1, {5'h1f, rnd[2:0]});
    cmd(8'hf3, 1'b1, rnd[15:8]);
    cmd(8'hee, 1'b0, 8'h00);
    frame(c);
    cmd(8'hfe, 1'b0, 8'h00);
    cmd(8'hff, 1'b0, 8'h00);
    inhibit_i = 1'b1;
    {cmd_byte_i, cmd_valid_i} = {8'hee, 1'b1};
    repeat (3) @(negedge clk_i);
    chk(cmd_busy_o === 1'b0 && ps2_clk_oe_o === 1'b1, "inhibit");
    cmd_valid_i = 1'b0;
    fork
      frame(c);
    join_none
    repeat (200) @(negedge clk_i);
    chk(exp_rx.size() == 1, "sent while held");
    inhibit_i = 1'b0;
    settle("inhibit");
    rst(1'b1);
    for (int k = 0; k < 12; k++)
    begin
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      frame(rnd[7:0] == 8'hfa ? 8'h7a : rnd[7:0]);
    end
    settle("mouse");
    chk(i_kbd.bad_n == 0, "partner");
    wrap_up();
  end
endmodule : ps2_host_port_tb
`default_nettype wire

// >>> dv/ps2hp_kbd_model.sv
`timescale 1ns/100ps
`default_nettype none
module ps2hp_kbd_model #(
  parameter int HALF_NS = 80
) (
  input wire logic ps2_clk_i,
  input wire logic ps2_dat_i,
  output logic clk_pull_o,
  output logic dat_pull_o
);
  logic [7:0] got_q[$];
  int bad_n = 0;
  logic [7:0] last_b = 8'haa;
  logic want_arg = 1'b0;
  initial
  begin
    clk_pull_o = 1'b0;
    dat_pull_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Lines released between frames; pull-ups leave both high
  task automatic pulse(input int half);
    #(half) clk_pull_o = 1'b1;
    #(half) clk_pull_o = 1'b0;
  endtask : pulse
  // Stray edges during reset must leave no frame behind
  task automatic flush();
    repeat (3) pulse(HALF_NS);
  endtask : flush
  // Start, eight bits LSB first, odd parity, stop, eleven clocks
  task automatic send_byte(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    int t;
    f = {1'b1, ~(^b) ^ bad, b, 1'b0};
    // Waits for both lines high, so a held clock stops it
    for (t = 0; t < 10000 && !(ps2_clk_i === 1'b1 && ps2_dat_i === 1'b1); t++) #20;
    if (t == 10000) bad_n++;
    if (b != 8'hfa && b != 8'hee) last_b = b;
    for (int i = 0; i < 11; i++)
    begin
      dat_pull_o = ~f[i];
      pulse(HALF_NS);
    end
    dat_pull_o = 1'b0;
  endtask : send_byte
  //////////////////////////////////////////////////////////////////////////////
  // Host request: data pulled low while clock held, then clock freed
  // Slower clock here: the host filters its clock input before acting
  always @(negedge ps2_dat_i)
  begin
    if (ps2_clk_i === 1'b0 && dat_pull_o === 1'b0) host_rx();
  end
  task automatic host_rx();
    logic [9:0] f;
    int t;
    for (t = 0; t < 10000 && ps2_clk_i !== 1'b1; t++) #20;
    if (t == 10000) bad_n++;
    for (int i = 0; i < 10; i++)
    begin
      pulse(HALF_NS * 4);
      f[i] = ps2_dat_i;
    end
    #(HALF_NS * 4) dat_pull_o = 1'b1;
    pulse(HALF_NS * 4);
    dat_pull_o = 1'b0;
    if (f[9] !== 1'b1 || f[8] !== ~(^f[7:0])) bad_n++;
    got_q.push_back(f[7:0]);
    #(HALF_NS * 8);
    if (want_arg)
    begin
      want_arg = 1'b0;
      send_byte(8'hfa, 1'b0);
    end
    else if (f[7:0] == 8'hed || f[7:0] == 8'hf3)
    begin
      want_arg = 1'b1;
      send_byte(8'hfa, 1'b0);
    end
    else if (f[7:0] == 8'hee) send_byte(8'hee, 1'b0);
    else if (f[7:0] == 8'hfe) send_byte(last_b, 1'b0);
    else send_byte(8'hfa, 1'b0);
  endtask : host_rx
endmodule : ps2hp_kbd_model
`default_nettype wire
